/* rtl/rxetx_pkg.sv */
// Purpose: shared constants and types of the receive status / early transmit register group
// Assumes: 32-bit APB data, one aligned word per register
// Notes: byte address of a register is four times its index
package rxetx_pkg;

    // ==========================================
    // register indices and byte addresses
    // ==========================================
    localparam logic [7:0] RXETX_IDX_STATUS = 8'h04; // rx_frame_status index
    localparam logic [7:0] RXETX_IDX_COUNT = 8'h06; // rx_frame_byte_count index
    localparam logic [7:0] RXETX_IDX_EARLY = 8'h08; // early_tx_control index
    localparam logic [7:0] RXETX_IDX_CTRL = 8'h0C; // receive control and frame release
    localparam logic [7:0] RXETX_IDX_EVENT = 8'h0E; // sticky event status, write one to clear
    localparam logic [7:0] RXETX_IDX_MASK = 8'h10; // event mask
    localparam logic [9:0] RXETX_ADDR_STATUS = {RXETX_IDX_STATUS, 2'b00};
    localparam logic [9:0] RXETX_ADDR_COUNT = {RXETX_IDX_COUNT, 2'b00};
    localparam logic [9:0] RXETX_ADDR_EARLY = {RXETX_IDX_EARLY, 2'b00};
    localparam logic [9:0] RXETX_ADDR_CTRL = {RXETX_IDX_CTRL, 2'b00};
    localparam logic [9:0] RXETX_ADDR_EVENT = {RXETX_IDX_EVENT, 2'b00};
    localparam logic [9:0] RXETX_ADDR_MASK = {RXETX_IDX_MASK, 2'b00};

    // ==========================================
    // field positions
    // ==========================================
    localparam int RXETX_BIT_VALID = 15; // frame_valid_flag
    localparam int RXETX_BIT_EARLY_EN = 7; // early_send_enable
    localparam int RXETX_BIT_PASS_BAD = 9; // pass bad frames in control
    localparam int RXETX_BIT_RELEASE = 0; // release head frame in control
    localparam int RXETX_EV_RX = 0; // frame delivered to the head
    localparam int RXETX_EV_DROP = 1; // frame discarded
    localparam int RXETX_EV_TX = 2; // transmission started
    localparam int RXETX_NUM_EV = 3;

    // ==========================================
    // widths, limits and reset values
    // ==========================================
    localparam int RXETX_CNT_W = 11; // byte count width
    localparam int RXETX_THR_W = 5; // early_send_threshold width
    localparam int RXETX_THR_SHIFT = 6; // threshold unit of 64 bytes
    localparam logic [15:0] RXETX_TYPE_LIMIT = 16'h05DC; // 1500, above is a type
    localparam logic [10:0] RXETX_MAX_LEN = 11'h77C; // 1916 bytes
    localparam logic [4:0] RXETX_THR_RST = 5'h00;
    localparam logic RXETX_EN_RST = 1'b0;

    // ==========================================
    // carriers
    // ==========================================
    // frame summary from the receive mac at frame end
    typedef struct packed {
        logic da_broadcast; // all-ones destination
        logic da_group; // group bit of destination
        logic mii_error; // symbol error seen
        logic runt; // cut short in collision window
        logic crc_error; // checksum failed
        logic [15:0] len_type; // length/type field
        logic [10:0] byte_count; // stored byte count
    } rxetx_frame_t;

    // stored status word layout, low byte
    typedef struct packed {
        logic broadcast; // bit 7
        logic group; // bit 6
        logic individual; // bit 5
        logic mii_err; // bit 4
        logic eth_type; // bit 3
        logic oversize; // bit 2
        logic runt; // bit 1
        logic crc_err; // bit 0
    } rxetx_status_t;

endpackage : rxetx_pkg

/* rtl/rxetx_regs.sv */
// Purpose: receive head status, byte count and early transmit registers behind APB
// Assumes: one pclk domain; the receive mac presents one frame summary per rx_end pulse
// Notes: the head holds one frame until software releases it; pready answers one cycle late
`timescale 1ns/1ps

// Operation
// - frame valid set when head frame complete
// - frame valid clear when nothing pending
// - status register mirrors stored frame status
// - broadcast bit for broadcast destination
// - multicast bit for group, including broadcast
// - unicast bit for individual destination
// - mii error bit on symbol error
// - type bit when length/type exceeds 1500
// - oversize bit above 1916 bytes
// - oversize never truncates the frame
// - oversize delivered only with pass-bad
// - runt bit; delivered only with pass-bad
// - crc error bit; delivered only with pass-bad
// - eleven-bit byte count from stored word
// - early send only while enable set
// - threshold is five bits, 64-byte units
// - start when written bytes exceed threshold
module rxetx_regs
    import rxetx_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive mac side
    input wire logic rx_end,
    input wire rxetx_frame_t rx_frame,
    output logic rx_head_busy,
    output logic rx_deliver,
    output logic rx_drop,
    // transmit side
    input wire logic tx_active,
    input wire logic [10:0] tx_bytes_written,
    input wire logic tx_frame_done,
    output logic tx_start,
    // interrupt
    output logic irq
);

    // ==========================================
    // apb access
    // ==========================================
    logic pready_q; // answer flag
    logic pready_d;
    logic pslverr_q; // unmapped address flag
    logic pslverr_d;
    logic [31:0] prdata_q; // read word
    logic [31:0] prdata_d;
    logic access; // access phase seen
    logic commit; // write takes effect now
    logic wr_status; // write to event status
    logic [31:0] rd_word; // decoded read value
    logic hit; // address is mapped

    // ==========================================
    // register state
    // ==========================================
    logic head_valid_q; // frame held at head
    logic head_valid_d;
    rxetx_status_t head_status_q; // stored status bits
    rxetx_status_t head_status_d;
    logic [10:0] head_count_q; // stored byte count
    logic [10:0] head_count_d;
    logic early_en_q; // early_send_enable
    logic early_en_d;
    logic [4:0] early_thr_q; // early_send_threshold
    logic [4:0] early_thr_d;
    logic pass_bad_q; // pass bad frames
    logic pass_bad_d;
    logic [RXETX_NUM_EV-1:0] ev_q; // sticky events
    logic [RXETX_NUM_EV-1:0] ev_d;
    logic [RXETX_NUM_EV-1:0] mask_q; // event mask
    logic [RXETX_NUM_EV-1:0] mask_d;
    logic [RXETX_NUM_EV-1:0] ev_set; // event pulses this cycle
    logic irq_q;
    logic irq_d;

    // ==========================================
    // receive and transmit state
    // ==========================================
    rxetx_status_t new_status; // status built at frame end
    logic new_bad; // frame has a bad-frame mark
    logic new_keep; // frame goes to the head
    logic release_req; // software releases head frame
    logic deliver_q;
    logic deliver_d;
    logic drop_q;
    logic drop_d;
    logic tx_start_q; // transmission started for this frame
    logic tx_start_d;
    logic [10:0] thr_bytes; // threshold in bytes

    // ==========================================
    // apb decode
    // ==========================================
    // read mux and address check
    always_comb
    begin
        access = psel && penable;
        rd_word = 32'h0000_0000;
        hit = 1'b1;
        case (paddr[9:0])
            RXETX_ADDR_STATUS:
            begin
                // valid flag plus stored low byte, rest zero
                rd_word[RXETX_BIT_VALID] = head_valid_q;
                rd_word[7:0] = head_valid_q ? head_status_q : 8'h00;
            end
            RXETX_ADDR_COUNT:
            begin
                rd_word[RXETX_CNT_W-1:0] = head_valid_q ? head_count_q : 11'h000;
            end
            RXETX_ADDR_EARLY:
            begin
                rd_word[RXETX_BIT_EARLY_EN] = early_en_q;
                rd_word[RXETX_THR_W-1:0] = early_thr_q;
            end
            RXETX_ADDR_CTRL:
            begin
                // release bit is self clearing, reads zero
                rd_word[RXETX_BIT_PASS_BAD] = pass_bad_q;
            end
            RXETX_ADDR_EVENT:
            begin
                rd_word[RXETX_NUM_EV-1:0] = ev_q;
            end
            RXETX_ADDR_MASK:
            begin
                rd_word[RXETX_NUM_EV-1:0] = mask_q;
            end
            default:
            begin
                // unmapped, reads zero and flags error
                hit = 1'b0;
            end
        endcase
        if (paddr[31:10] != 22'h000000)
        begin
            hit = 1'b0;
        end
        // write lands only in the answer cycle of a mapped address
        commit = access && pready_q && pwrite && hit;
        wr_status = commit && (paddr[9:0] == RXETX_ADDR_EVENT);
        release_req = commit && (paddr[9:0] == RXETX_ADDR_CTRL) && pwdata[RXETX_BIT_RELEASE];
    end

    // next values of the bus answer
    always_comb
    begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (access && !pready_q)
        begin
            // answer in the second access cycle
            pready_d = 1'b1;
            pslverr_d = !hit;
            prdata_d = (hit && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ==========================================
    // software-written control
    // ==========================================
    // writes land only on writable fields
    always_comb
    begin
        early_en_d = early_en_q;
        early_thr_d = early_thr_q;
        pass_bad_d = pass_bad_q;
        mask_d = mask_q;
        if (commit && (paddr[9:0] == RXETX_ADDR_EARLY))
        begin
            early_en_d = pwdata[RXETX_BIT_EARLY_EN];
            early_thr_d = pwdata[RXETX_THR_W-1:0];
        end
        if (commit && (paddr[9:0] == RXETX_ADDR_CTRL))
        begin
            pass_bad_d = pwdata[RXETX_BIT_PASS_BAD];
        end
        if (commit && (paddr[9:0] == RXETX_ADDR_MASK))
        begin
            mask_d = pwdata[RXETX_NUM_EV-1:0];
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            early_en_q <= RXETX_EN_RST;
            early_thr_q <= RXETX_THR_RST;
            pass_bad_q <= 1'b0;
            mask_q <= '0;
        end
        else
        begin
            early_en_q <= early_en_d;
            early_thr_q <= early_thr_d;
            pass_bad_q <= pass_bad_d;
            mask_q <= mask_d;
        end
    end

    // ==========================================
    // receive head
    // ==========================================
    // build the status word of the ending frame
    always_comb
    begin
        new_status.broadcast = rx_frame.da_broadcast;
        new_status.group = rx_frame.da_group || rx_frame.da_broadcast;
        new_status.individual = !rx_frame.da_group && !rx_frame.da_broadcast;
        new_status.mii_err = rx_frame.mii_error;
        new_status.eth_type = rx_frame.len_type > RXETX_TYPE_LIMIT;
        new_status.oversize = rx_frame.byte_count > RXETX_MAX_LEN;
        new_status.runt = rx_frame.runt;
        new_status.crc_err = rx_frame.crc_error;
        // bad frames pass only when software allows it
        new_bad = new_status.oversize || new_status.runt || new_status.crc_err;
        new_keep = !new_bad || pass_bad_q;
    end

    // head update, release and frame end
    always_comb
    begin
        head_valid_d = head_valid_q;
        head_status_d = head_status_q;
        head_count_d = head_count_q;
        deliver_d = 1'b0;
        drop_d = 1'b0;
        if (release_req)
        begin
            // head freed, valid falls until next frame
            head_valid_d = 1'b0;
        end
        if (rx_end)
        begin
            if (new_keep && !head_valid_q)
            begin
                // valid only once the whole frame is in
                head_valid_d = 1'b1;
                head_status_d = new_status;
                head_count_d = rx_frame.byte_count;
                deliver_d = 1'b1;
            end
            else
            begin
                // discarded, or head still occupied
                drop_d = 1'b1;
            end
        end
    end

    // head registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            head_valid_q <= 1'b0;
            head_status_q <= '0;
            head_count_q <= 11'h000;
            deliver_q <= 1'b0;
            drop_q <= 1'b0;
        end
        else
        begin
            head_valid_q <= head_valid_d;
            head_status_q <= head_status_d;
            head_count_q <= head_count_d;
            deliver_q <= deliver_d;
            drop_q <= drop_d;
        end
    end

    // ==========================================
    // early transmit
    // ==========================================
    // start early past threshold, else at frame done
    always_comb
    begin
        thr_bytes = {early_thr_q, {RXETX_THR_SHIFT{1'b0}}};
        tx_start_d = tx_start_q;
        if (!tx_active)
        begin
            // idle between frames
            tx_start_d = 1'b0;
        end
        else if (early_en_q && (tx_bytes_written > thr_bytes))
        begin
            // zero threshold is left to the host to avoid
            tx_start_d = 1'b1;
        end
        else if (tx_frame_done)
        begin
            // normal transmission after whole frame written
            tx_start_d = 1'b1;
        end
    end

    // transmit start register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_start_q <= 1'b0;
        end
        else
        begin
            tx_start_q <= tx_start_d;
        end
    end

    // ==========================================
    // events and interrupt
    // ==========================================
    // sticky bits, set wins over write-one clear
    always_comb
    begin
        ev_set = '0;
        ev_set[RXETX_EV_RX] = deliver_d;
        ev_set[RXETX_EV_DROP] = drop_d;
        ev_set[RXETX_EV_TX] = tx_start_d && !tx_start_q;
        ev_d = ev_q;
        if (wr_status)
        begin
            ev_d = ev_q & ~pwdata[RXETX_NUM_EV-1:0];
        end
        ev_d = ev_d | ev_set;
        irq_d = |(ev_d & mask_d);
    end

    // event and interrupt registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            ev_q <= ev_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================
    // outputs
    // ==========================================
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_head_busy = head_valid_q;
    assign rx_deliver = deliver_q;
    assign rx_drop = drop_q;
    assign tx_start = tx_start_q;
    assign irq = irq_q;

endmodule : rxetx_regs

/* verification/rxetx_regs_props.sv */
// Purpose: port-level checks of the receive head / early transmit register block
// Assumes: single pclk domain, presetn active low
// Notes: bound into every instance of the design
`timescale 1ns/1ps
module rxetx_regs_props
    import rxetx_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // receive and transmit
    input wire logic rx_end,
    input wire logic rx_head_busy,
    input wire logic rx_deliver,
    input wire logic rx_drop,
    input wire logic tx_active,
    input wire logic tx_frame_done,
    input wire logic tx_start
);
    // ==========================================
    // checks
    // ==========================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // one wait state, then a single-cycle answer
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!(psel && penable) |=> !pready && !pslverr)
        else $error("answer without access");
    a_unmapped_err: assert property (psel && penable && pready && paddr[31:10] != 22'h0 |-> pslverr)
        else $error("out of range access not refused");
    // every frame end gets exactly one verdict
    a_rx_verdict: assert property (rx_end |=> rx_deliver ^ rx_drop)
        else $error("frame end without single verdict");
    a_rx_no_verdict: assert property (!rx_end |=> !rx_deliver && !rx_drop)
        else $error("verdict without frame end");
    a_full_drop: assert property (rx_end && rx_head_busy |=> rx_drop)
        else $error("frame accepted over held head");
    a_deliver_valid: assert property (rx_deliver |-> rx_head_busy)
        else $error("delivered frame not flagged valid");
    a_head_hold: assert property (rx_head_busy && !(psel && pwrite) |=> rx_head_busy)
        else $error("head lost without release");
    a_tx_stop: assert property (!tx_active |=> !tx_start)
        else $error("transmit start outside frame");
    a_tx_normal: assert property (tx_active && tx_frame_done |=> tx_start)
        else $error("whole frame written but not started");
endmodule : rxetx_regs_props

bind rxetx_regs rxetx_regs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .rx_end(rx_end),
    .rx_head_busy(rx_head_busy), .rx_deliver(rx_deliver), .rx_drop(rx_drop), .tx_active(tx_active),
    .tx_frame_done(tx_frame_done), .tx_start(tx_start));

/* verification/rxetx_mac_model.sv */
// Purpose: receive mac stand-in that hands frame summaries to the block
// Assumes: one summary per rx_end pulse
// Notes: summary lines show the inverse of the last frame between pulses
`timescale 1ns/1ps
module rxetx_mac_model
    import rxetx_pkg::*;
(
    // clock
    input wire logic pclk,
    // frame summary out
    output logic rx_end,
    output rxetx_frame_t rx_frame
);
    // ==========================================
    // frame sender
    // ==========================================
    initial
    begin
        rx_end = 1'b0;
        rx_frame = '0;
    end
    // one-cycle pulse, then garbage so stale data never looks valid
    task automatic send_frame(input rxetx_frame_t f);
        @(posedge pclk);
        rx_end <= 1'b1;
        rx_frame <= f;
        @(posedge pclk);
        rx_end <= 1'b0;
        rx_frame <= ~f;
    endtask : send_frame
endmodule : rxetx_mac_model

/* verification/tb.sv */
// Purpose: register, receive head, interrupt and early transmit tests
// Assumes: apb master per the hand-over timing
// Notes: self-checking, ends in close_out
`timescale 1ns/1ps
module tb
    import rxetx_pkg::*;
;
    // ==========================================
    // signals
    // ==========================================
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic serr; // pslverr taken with the answer
    logic rx_end, rx_head_busy, rx_deliver, rx_drop, irq;
    rxetx_frame_t rx_frame;
    logic tx_active, tx_frame_done, tx_start;
    logic [10:0] tx_bytes_written;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    rxetx_frame_t fr [5];
    localparam logic [31:0] A_ST = {22'h0, RXETX_ADDR_STATUS};
    localparam logic [31:0] A_CNT = {22'h0, RXETX_ADDR_COUNT};
    localparam logic [31:0] A_ETX = {22'h0, RXETX_ADDR_EARLY};
    localparam logic [31:0] A_CTL = {22'h0, RXETX_ADDR_CTRL};
    localparam logic [31:0] A_EV = {22'h0, RXETX_ADDR_EVENT};
    localparam logic [31:0] A_MSK = {22'h0, RXETX_ADDR_MASK};

    always #12.5 pclk = ~pclk;

    rxetx_regs u_rxetx_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_end(rx_end),
        .rx_frame(rx_frame), .rx_head_busy(rx_head_busy), .rx_deliver(rx_deliver), .rx_drop(rx_drop),
        .tx_active(tx_active), .tx_bytes_written(tx_bytes_written), .tx_frame_done(tx_frame_done),
        .tx_start(tx_start), .irq(irq));
    rxetx_mac_model u_rxetx_mac_model (.pclk(pclk), .rx_end(rx_end), .rx_frame(rx_frame));

    // ==========================================
    // tasks
    // ==========================================
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // full apb transfer; answer taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait; the hang guard ends it if pready never comes
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdat);
        chk(rdat, exp);
    endtask : rd

    // expected status word worked out from the frame summary
    function automatic logic [31:0] exp_st(input rxetx_frame_t f);
        logic grp;
        grp = f.da_group | f.da_broadcast;
        return {16'h0, 1'b1, 7'h0, f.da_broadcast, grp, ~grp, f.mii_error, f.len_type > RXETX_TYPE_LIMIT,
            f.byte_count > RXETX_MAX_LEN, f.runt, f.crc_error};
    endfunction : exp_st

    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial
    begin
        fr[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0800, 11'h040};
        fr[1] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h05DC, 11'h77C};
        fr[2] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h05DD, 11'h77D};
        fr[3] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 11'h028};
        fr[4] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0600, 11'h064};
        {presetn, psel, penable, pwrite, tx_active, tx_frame_done} = 6'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        tx_bytes_written = 11'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and access kinds
        rd(A_ETX, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_CNT, 32'h0);
        rd(A_EV, 32'h0);
        wr(A_ETX, 32'hFFFF_FFFF);
        rd(A_ETX, 32'h0000_009F);
        wr(A_ST, 32'hFFFF_FFFF);
        rd(A_ST, 32'h0);
        apb(1'b0, 32'h0000_0400, 32'h0, rdat);
        chk({rdat[30:0], serr}, 32'h1);
        // good and bad frames kept with pass-bad set
        wr(A_CTL, 32'h0000_0200);
        for (int i = 0; i < 5; i++)
        begin
            u_rxetx_mac_model.send_frame(fr[i]);
            rd(A_ST, exp_st(fr[i]));
            rd(A_ST, exp_st(fr[i]));
            chk({31'h0, rx_head_busy}, 32'h1);
            rd(A_CNT, {21'h0, fr[i].byte_count});
            rd(A_EV, 32'h1);
            wr(A_EV, 32'h7);
            wr(A_CTL, 32'h0000_0201);
            rd(A_ST, 32'h0);
            chk({31'h0, rx_head_busy}, 32'h0);
        end
        // bad frames dropped without pass-bad; drop event raises irq
        wr(A_CTL, 32'h0);
        wr(A_MSK, 32'h2);
        for (int i = 2; i < 5; i++)
        begin
            u_rxetx_mac_model.send_frame(fr[i]);
            rd(A_ST, 32'h0);
            @(negedge pclk);
            chk({31'h0, irq}, 32'h1);
            wr(A_EV, 32'h2);
            @(negedge pclk);
            chk({31'h0, irq}, 32'h0);
        end
        // held head refuses the next frame; masked events stay quiet
        wr(A_MSK, 32'h0);
        u_rxetx_mac_model.send_frame(fr[0]);
        @(negedge pclk);
        chk({30'h0, rx_deliver, rx_drop}, 32'h2);
        u_rxetx_mac_model.send_frame(fr[1]);
        @(negedge pclk);
        chk({30'h0, rx_deliver, rx_drop}, 32'h1);
        rd(A_ST, exp_st(fr[0]));
        rd(A_EV, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(A_CNT, 32'hFFFF_FFFF);
        rd(A_CNT, {21'h0, fr[0].byte_count});
        wr(A_EV, 32'h7);
        wr(A_CTL, 32'h1);
        // early transmit at both threshold ends, never zero while enabled
        for (int t = 1; t < 32; t += 30)
        begin
            wr(A_ETX, 32'h80 | t);
            tx_active <= 1'b1;
            tx_bytes_written <= 11'(t * 64);
            repeat (3) @(negedge pclk);
            chk({31'h0, tx_start}, 32'h0);
            @(posedge pclk);
            tx_bytes_written <= 11'(t * 64 + 1);
            repeat (2) @(negedge pclk);
            chk({31'h0, tx_start}, 32'h1);
            rd(A_EV, 32'h4);
            wr(A_EV, 32'h4);
            tx_active <= 1'b0;
            repeat (2) @(negedge pclk);
            chk({31'h0, tx_start}, 32'h0);
        end
        // disabled: only the whole frame starts transmission
        wr(A_ETX, 32'h01);
        tx_active <= 1'b1;
        tx_bytes_written <= 11'h7D0;
        repeat (3) @(negedge pclk);
        chk({31'h0, tx_start}, 32'h0);
        @(posedge pclk);
        tx_frame_done <= 1'b1;
        repeat (2) @(negedge pclk);
        chk({31'h0, tx_start}, 32'h1);
        close_out();
    end
endmodule : tb
